// *** rtl/csr_seq_consts.svh ***
// Purpose: Shared widths and reset values of the context save and restore sequencer
// Assumes: Included by bare name from the package and the design
// Notes: Definitions only
`ifndef CSR_SEQ_CONSTS_SVH
`define CSR_SEQ_CONSTS_SVH

// Real-time count, match value and stamp width
`define CSR_CNT_W 40
// Reset values of the counter, the match value and the version count
`define CSR_CNT_RESET 40'h00_0000_0000
`define CSR_MATCH_RESET 40'hFF_FFFF_FFFF
`define CSR_VER_RESET 40'h00_0000_0000
// Word offset of the stamp inside a saved slot; context words follow it
`define CSR_STAMP_WORD 0
`define CSR_DATA_WORD0 1

`endif

// *** rtl/csr_seq_pkg.sv ***
// Purpose: Types of the context save and restore sequencer
// Assumes: Constants come from csr_seq_consts.svh
// Notes: State codes are one-hot
`include "csr_seq_consts.svh"

package csr_seq_pkg;

    typedef logic [`CSR_CNT_W-1:0] stamp_t;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_STAGE = 7'h02,
        ST_PROG  = 7'h04,
        ST_SLEEP = 7'h08,
        ST_SCAN  = 7'h10,
        ST_LOAD  = 7'h20,
        ST_DONE  = 7'h40
    } state_t;

endpackage

// *** rtl/context_save_restore_sequencer.sv ***
// Purpose: Saves fabric context with a stamp to flash, sleeps, wakes and restores it
// Assumes: One clock sys_clk; crystal clock and wake pin are sampled as plain inputs
// Notes: Flash and context source answer on sys_clk
// Functional notes
// - 40-bit counter, 40-bit match value, match flag
// - Counter stamps contexts (version count if useVersion) and wakes at match
// - Count and match readable and writable by fabric
// - Counter advances on external crystal clock
// - Save stages context plus stamp first
// - Staged context then written to flash
// - Regulator off only after flash write ends
// - Regulator back on at match or wake
// - After wake, reload context from flash
// - Flash keeps several slots, each stamped
`timescale 1ns/1ps
`include "csr_seq_consts.svh"

module context_save_restore_sequencer
    import csr_seq_pkg::*;
#(
    parameter int WORDS = 8,
    parameter int DW = 32,
    parameter int NSLOT = 4,
    parameter int AW = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // External pins
    input wire logic xtalClk,
    input wire logic wakeIn,
    output logic regEn,
    // Fabric access to the counter
    input wire logic countWr,
    input wire logic [`CSR_CNT_W-1:0] countWrData,
    input wire logic matchWr,
    input wire logic [`CSR_CNT_W-1:0] matchWrData,
    input wire logic matchFlagClr,
    output logic [`CSR_CNT_W-1:0] rtcCount,
    output logic [`CSR_CNT_W-1:0] rtcMatch,
    output logic matchFlag,
    // Save control
    input wire logic saveReq,
    input wire logic useVersion,
    // Context source, read combinationally
    output logic [$clog2(WORDS)-1:0] ctxAddr,
    input wire logic [DW-1:0] ctxRdData,
    // Flash port
    output logic flashReq,
    output logic flashWe,
    output logic [AW-1:0] flashAddr,
    output logic [`CSR_CNT_W-1:0] flashWrData,
    input wire logic [`CSR_CNT_W-1:0] flashRdData,
    input wire logic flashDone,
    // Restore output
    output logic rstWrEn,
    output logic [$clog2(WORDS)-1:0] rstAddr,
    output logic [DW-1:0] rstData,
    output logic restoreDone,
    output logic appReady
);

    localparam int IW = $clog2(WORDS);
    localparam int SW = $clog2(NSLOT);
    localparam int WW = $clog2(WORDS + 1);

    function automatic logic [AW-1:0] slotAddr(input logic [SW-1:0] slot,
                                                input logic [WW-1:0] word);
        slotAddr = AW'(slot) * AW'(WORDS + 1) + AW'(word);
    endfunction

    logic xSync1_q, xSync2_q, xSync3_q;
    logic wSync1_q, wSync2_q;
    logic [`CSR_CNT_W-1:0] count_q, match_q;
    logic flag_q;
    logic tick, hit;
    state_t state_q;
    logic [DW-1:0] stage_q [WORDS];
    stamp_t stamp_q, version_q, best_q;
    logic [IW-1:0] idx_q;
    logic [WW-1:0] word_q;
    logic [SW-1:0] slot_q, scan_q, bestSlot_q;
    logic regEn_q, req_q, we_q, rstWrEn_q, done_q, ready_q;
    logic [AW-1:0] addr_q;
    logic [`CSR_CNT_W-1:0] wrData_q;
    logic [IW-1:0] rstAddr_q;
    logic [DW-1:0] rstData_q;
    logic wordLast, wakeEvt;

    // Crystal clock and wake pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            xSync1_q <= 1'b0;
            xSync2_q <= 1'b0;
            xSync3_q <= 1'b0;
            wSync1_q <= 1'b0;
            wSync2_q <= 1'b0;
        end else begin
            xSync1_q <= xtalClk;
            xSync2_q <= xSync1_q;
            xSync3_q <= xSync2_q;
            wSync1_q <= wakeIn;
            wSync2_q <= wSync1_q;
        end
    end

    assign tick = xSync2_q & ~xSync3_q;
    assign hit = (count_q == match_q);

    // Real-time counter and match value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q <= `CSR_CNT_RESET;
            match_q <= `CSR_MATCH_RESET;
        end else begin
            if (countWr) begin
                count_q <= countWrData;
            end else if (tick) begin
                count_q <= count_q + 40'h00_0000_0001;
            end
            if (matchWr) begin
                match_q <= matchWrData;
            end
        end
    end

    // Sticky match flag; a hit in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (hit) begin
            flag_q <= 1'b1;
        end else if (matchFlagClr) begin
            flag_q <= 1'b0;
        end
    end

    assign wordLast = (word_q == WW'(WORDS));
    assign wakeEvt = flag_q | wSync2_q;

    // Sequencer state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (saveReq) begin
                        state_q <= ST_STAGE;
                    end
                end
                ST_STAGE: begin
                    if (idx_q == IW'(WORDS - 1)) begin
                        state_q <= ST_PROG;
                    end
                end
                ST_PROG: begin
                    if (flashDone && wordLast) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wakeEvt) begin
                        state_q <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (flashDone && scan_q == SW'(NSLOT - 1)) begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (flashDone && wordLast) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Staging in on-chip storage, stamp taken at entry
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idx_q <= '0;
            stamp_q <= `CSR_CNT_RESET;
            version_q <= `CSR_VER_RESET;
        end else if (state_q == ST_IDLE && saveReq) begin
            idx_q <= '0;
            version_q <= version_q + 40'h00_0000_0001;
            stamp_q <= useVersion ? version_q + 40'h00_0000_0001 : count_q;
        end else if (state_q == ST_STAGE) begin
            idx_q <= idx_q + IW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (state_q == ST_STAGE) begin
            stage_q[idx_q] <= ctxRdData;
        end
    end

    // Word, slot and scan pointers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            word_q <= '0;
            slot_q <= '0;
            scan_q <= '0;
        end else begin
            if (state_q == ST_SCAN) begin
                word_q <= WW'(`CSR_DATA_WORD0);
            end else if (state_q == ST_STAGE || state_q == ST_SLEEP) begin
                word_q <= WW'(`CSR_STAMP_WORD);
            end else if ((state_q == ST_PROG || state_q == ST_LOAD) && flashDone) begin
                word_q <= word_q + WW'(1);
            end
            if (state_q == ST_PROG && flashDone && wordLast) begin
                slot_q <= (slot_q == SW'(NSLOT - 1)) ? '0 : slot_q + SW'(1);
            end
            if (state_q == ST_SLEEP) begin
                scan_q <= '0;
            end else if (state_q == ST_SCAN && flashDone) begin
                scan_q <= scan_q + SW'(1);
            end
        end
    end

    // Newest stamp search
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            best_q <= `CSR_CNT_RESET;
            bestSlot_q <= '0;
        end else if (state_q == ST_SLEEP) begin
            best_q <= `CSR_CNT_RESET;
            bestSlot_q <= '0;
        end else if (state_q == ST_SCAN && flashDone && flashRdData >= best_q) begin
            best_q <= flashRdData;
            bestSlot_q <= scan_q;
        end
    end

    // Flash request, held until the flash answers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wrData_q <= '0;
        end else begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            if (state_q == ST_PROG && !(flashDone && wordLast)) begin
                req_q <= 1'b1;
                we_q <= 1'b1;
                addr_q <= slotAddr(slot_q, flashDone ? word_q + WW'(1) : word_q);
                if (!flashDone && word_q == WW'(`CSR_STAMP_WORD)) begin
                    wrData_q <= stamp_q;
                end else begin
                    wrData_q <= `CSR_CNT_W'(stage_q[IW'((flashDone ? word_q : word_q - WW'(1)))]);
                end
            end else if (state_q == ST_SCAN && !(flashDone && scan_q == SW'(NSLOT - 1))) begin
                req_q <= 1'b1;
                addr_q <= slotAddr(flashDone ? scan_q + SW'(1) : scan_q,
                                   WW'(`CSR_STAMP_WORD));
            end else if (state_q == ST_LOAD && !(flashDone && wordLast)) begin
                req_q <= 1'b1;
                addr_q <= slotAddr(bestSlot_q, flashDone ? word_q + WW'(1) : word_q);
            end
        end
    end

    // Regulator enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regEn_q <= 1'b1;
        end else if (state_q == ST_PROG && flashDone && wordLast) begin
            regEn_q <= 1'b0;
        end else if (state_q == ST_SLEEP && wakeEvt) begin
            regEn_q <= 1'b1;
        end
    end

    // Restore writes and completion
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rstWrEn_q <= 1'b0;
            rstAddr_q <= '0;
            rstData_q <= '0;
            done_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            rstWrEn_q <= 1'b0;
            done_q <= 1'b0;
            if (state_q == ST_LOAD && flashDone) begin
                rstWrEn_q <= 1'b1;
                rstAddr_q <= IW'(word_q - WW'(`CSR_DATA_WORD0));
                rstData_q <= DW'(flashRdData);
            end
            if (state_q == ST_IDLE && saveReq) begin
                ready_q <= 1'b0;
            end else if (state_q == ST_DONE) begin
                done_q <= 1'b1;
                ready_q <= 1'b1;
            end
        end
    end

    assign regEn = regEn_q;
    assign rtcCount = count_q;
    assign rtcMatch = match_q;
    assign matchFlag = flag_q;
    assign ctxAddr = idx_q;
    assign flashReq = req_q;
    assign flashWe = we_q;
    assign flashAddr = addr_q;
    assign flashWrData = wrData_q;
    assign rstWrEn = rstWrEn_q;
    assign rstAddr = rstAddr_q;
    assign rstData = rstData_q;
    assign restoreDone = done_q;
    assign appReady = ready_q;

    sequence seqSaveStart;
        state_q == ST_IDLE && saveReq;
    endsequence

    sequence seqProgEnd;
        state_q == ST_PROG && flashDone && wordLast;
    endsequence

    AST_MATCH_SET: assert property (@(posedge sys_clk) disable iff (rst)
        hit |=> flag_q)
        else $error("match flag not set on count match");

    AST_TICK_INC: assert property (@(posedge sys_clk) disable iff (rst)
        tick && !countWr |=> count_q == $past(count_q) + 40'h00_0000_0001)
        else $error("counter did not advance on crystal edge");

    AST_MATCH_WR: assert property (@(posedge sys_clk) disable iff (rst)
        matchWr |=> match_q == $past(matchWrData))
        else $error("match value not written");

    AST_STAMP: assert property (@(posedge sys_clk) disable iff (rst)
        (seqSaveStart and !useVersion) |=> stamp_q == $past(count_q) && state_q == ST_STAGE)
        else $error("save did not take real-time stamp");

    // Staging length checked for the default of eight context words
    AST_STAGE_LEN: assert property (@(posedge sys_clk) disable iff (rst)
        seqSaveStart |=> (state_q == ST_STAGE) [*8] ##1 state_q == ST_PROG)
        else $error("staging length wrong");

    AST_REG_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(regEn_q) |-> $past(state_q) == ST_PROG && $past(flashDone))
        else $error("regulator off before flash write ended");

    AST_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_SLEEP && wakeEvt |=> regEn_q && state_q == ST_SCAN)
        else $error("no wake on match or pin");

    AST_SLOT_ADV: assert property (@(posedge sys_clk) disable iff (rst)
        seqProgEnd |=> state_q == ST_SLEEP && slot_q != $past(slot_q))
        else $error("slot pointer did not advance");

    AST_LOAD_SLOT: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_LOAD && req_q |-> addr_q >= slotAddr(bestSlot_q, WW'(1))
            && addr_q <= slotAddr(bestSlot_q, WW'(WORDS)))
        else $error("restore read outside newest slot");

    AST_DONE: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(ready_q) |-> done_q && $past(state_q) == ST_DONE)
        else $error("application released before restore done");

endmodule

// *** sim/flash_model.sv ***
// Purpose: Flash memory partner of the context sequencer
// Assumes: One request at a time, answered on sys_clk
// Notes: lat adds wait cycles before each answer; read data is junk outside flashDone
`timescale 1ns/1ps
`include "csr_seq_consts.svh"

module flash_model #(
    parameter int AW = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Answer delay
    input wire logic [1:0] lat,
    // Flash port
    input wire logic flashReq,
    input wire logic flashWe,
    input wire logic [AW-1:0] flashAddr,
    input wire logic [`CSR_CNT_W-1:0] flashWrData,
    output logic [`CSR_CNT_W-1:0] flashRdData,
    output logic flashDone
);
    logic [`CSR_CNT_W-1:0] mem [0:63];
    logic busy_q;
    logic [1:0] wait_q;

    // Erased cells read as zero
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 40'h00_0000_0000;
        end
        flashRdData = 40'h00_0000_0000;
        flashDone = 1'b0;
    end

    always @(posedge sys_clk) begin
        flashDone <= 1'b0;
        flashRdData <= ~flashRdData;
        if (rst) begin
            busy_q <= 1'b0;
            wait_q <= 2'h0;
        end else if (flashReq && !flashDone && !busy_q) begin
            busy_q <= 1'b1;
            wait_q <= lat;
        end else if (busy_q && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            flashDone <= 1'b1;
            if (flashWe) begin
                mem[flashAddr[5:0]] <= flashWrData;
            end else begin
                flashRdData <= mem[flashAddr[5:0]];
            end
        end
    end
endmodule

// *** sim/context_save_restore_sequencer_tb_top.sv ***
// Purpose: Self-checking bench of the context save and restore sequencer
// Assumes: Default parameters; crystal ticks made by the bench
// Notes: Flash writes and restored words are checked against a queue of notes
`timescale 1ns/1ps
`include "csr_seq_consts.svh"

module context_save_restore_sequencer_tb_top import csr_seq_pkg::*; ();
    localparam int W = 8;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic xtalClk = 1'b0, wakeIn = 1'b0, countWr = 1'b0, matchWr = 1'b0;
    logic matchFlagClr = 1'b0, saveReq = 1'b0, useVersion = 1'b0;
    logic [1:0] lat = 2'h0;
    logic [39:0] countWrData = 40'h00_0000_0000, matchWrData = 40'h00_0000_0000;
    logic regEn, matchFlag, flashReq, flashWe, flashDone, rstWrEn, restoreDone, appReady;
    logic [39:0] rtcCount, rtcMatch, flashWrData, flashRdData;
    logic [2:0] ctxAddr, rstAddr;
    logic [15:0] flashAddr;
    logic [31:0] ctxRdData, rstData;
    logic [31:0] ctxWords [0:7];
    logic [31:0] slotData [0:3][0:7];
    stamp_t slotStamp [0:3];
    logic [63:0] notes [$];
    int nErrors = 0, nChecks = 0, seed = 25, sp = 0;

    always #2.5 sys_clk = ~sys_clk;
    assign ctxRdData = ctxWords[ctxAddr];

    context_save_restore_sequencer dut (.sys_clk(sys_clk), .rst(rst), .xtalClk(xtalClk),
        .wakeIn(wakeIn), .regEn(regEn), .countWr(countWr), .countWrData(countWrData),
        .matchWr(matchWr), .matchWrData(matchWrData), .matchFlagClr(matchFlagClr),
        .rtcCount(rtcCount), .rtcMatch(rtcMatch), .matchFlag(matchFlag), .saveReq(saveReq),
        .useVersion(useVersion), .ctxAddr(ctxAddr), .ctxRdData(ctxRdData),
        .flashReq(flashReq), .flashWe(flashWe), .flashAddr(flashAddr),
        .flashWrData(flashWrData), .flashRdData(flashRdData), .flashDone(flashDone),
        .rstWrEn(rstWrEn), .rstAddr(rstAddr), .rstData(rstData),
        .restoreDone(restoreDone), .appReady(appReady));

    flash_model flash (.sys_clk(sys_clk), .rst(rst), .lat(lat), .flashReq(flashReq),
        .flashWe(flashWe), .flashAddr(flashAddr), .flashWrData(flashWrData),
        .flashRdData(flashRdData), .flashDone(flashDone));

    task automatic endOfTest();
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pop(input logic [63:0] got);
        if (notes.size() == 0) begin
            check(got, ~got);
        end else begin
            check(got, notes.pop_front());
        end
    endtask

    // Watcher side: every flash write and restored word takes the oldest note
    always @(posedge sys_clk) begin
        if (!rst && flashReq === 1'b1 && flashWe === 1'b1 && flashDone === 1'b1) begin
            pop({8'h00, flashAddr, flashWrData});
        end
        if (!rst && rstWrEn === 1'b1) begin
            pop({8'h80, 13'h0000, rstAddr, 8'h00, rstData});
        end
    end

    task automatic waitSig(input bit useApp, input logic v);
        for (int i = 0; i <= 3000; i++) begin
            @(negedge sys_clk);
            if ((useApp ? appReady : regEn) === v) begin
                return;
            end
        end
        nErrors++;
        endOfTest();
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            xtalClk = 1'b1;
            repeat (3) @(negedge sys_clk);
            xtalClk = 1'b0;
            repeat (3) @(negedge sys_clk);
        end
    endtask

    task automatic doSave(input logic ver, input logic [39:0] stamp);
        int base;
        base = sp * (W + 1);
        lat = 2'($random(seed));
        notes.push_back({8'h00, 16'(base), stamp});
        for (int i = 0; i < W; i++) begin
            ctxWords[i] = $random(seed);
            slotData[sp][i] = ctxWords[i];
            notes.push_back({8'h00, 16'(base + 1 + i), 8'h00, ctxWords[i]});
        end
        slotStamp[sp] = stamp;
        useVersion = ver;
        saveReq = 1'b1;
        @(negedge sys_clk);
        saveReq = 1'b0;
        @(negedge sys_clk);
        check(64'(appReady), 64'h0);
        waitSig(1'b0, 1'b0);
        check(64'(notes.size()), 64'h0);
        sp = (sp + 1) % 4;
    endtask

    task automatic doWake(input logic pin);
        int best;
        best = 0;
        for (int s = 1; s < 4; s++) begin
            if (slotStamp[s] >= slotStamp[best]) begin
                best = s;
            end
        end
        for (int i = 0; i < W; i++) begin
            notes.push_back({8'h80, 13'h0000, 3'(i), 8'h00, slotData[best][i]});
        end
        if (pin) begin
            wakeIn = 1'b1;
        end else begin
            tick(2);
        end
        waitSig(1'b1, 1'b1);
        check(64'(restoreDone), 64'h1);
        wakeIn = 1'b0;
        check(64'(regEn), 64'h1);
        check(64'(notes.size()), 64'h0);
    endtask

    initial begin
        for (int s = 0; s < 4; s++) begin
            slotStamp[s] = 40'h00_0000_0000;
        end
        for (int i = 0; i < W; i++) begin
            ctxWords[i] = 32'h0000_0000;
        end
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        check(64'({regEn, appReady, matchFlag, flashReq, rstWrEn, restoreDone}), 64'h30);
        check(64'(rtcCount), 64'(`CSR_CNT_RESET));
        check(64'(rtcMatch), 64'(`CSR_MATCH_RESET));
        countWr = 1'b1;
        countWrData = 40'h00_0000_0120;
        @(negedge sys_clk);
        countWr = 1'b0;
        tick(3);
        check(64'(rtcCount), 64'h123);
        matchWr = 1'b1;
        matchWrData = 40'h00_0000_0125;
        @(negedge sys_clk);
        matchWr = 1'b0;
        @(negedge sys_clk);
        check(64'({rtcMatch, matchFlag}), 64'h24A);
        doSave(1'b0, 40'h00_0000_0123);
        // A save request while asleep must be ignored
        saveReq = 1'b1;
        @(negedge sys_clk);
        saveReq = 1'b0;
        repeat (5) @(negedge sys_clk);
        check(64'({flashReq, regEn}), 64'h0);
        doWake(1'b1);
        // Version count advances on every save, so the second save stamps two
        doSave(1'b1, 40'h00_0000_0002);
        doWake(1'b0);
        check(64'(matchFlag), 64'h1);
        tick(1);
        matchFlagClr = 1'b1;
        @(negedge sys_clk);
        matchFlagClr = 1'b0;
        @(negedge sys_clk);
        check(64'(matchFlag), 64'h0);
        endOfTest();
    end
endmodule
